// >>> verilog/ivpc_top.sv
`timescale 1ns/1ns
module ivpc_top #(
    parameter int PING_CYC = ivpc_pkg::PING_TIME_US * (ivpc_pkg::CLK_HZ / 1_000_000),
    parameter int GAP_CYC = ivpc_pkg::GAP_TIME_US * (ivpc_pkg::CLK_HZ / 1_000_000)
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SS_RX,
    input wire logic SAMPLE_VALID,
    input wire logic [15:0] COIL_MV,
    input wire logic DET_VALID,
    input wire logic signed [7:0] DET_OFFSET,
    output logic [15:0] VSET,
    output logic PWR_EN,
    output logic BRIDGE_A,
    output logic BRIDGE_B,
    output logic IND_LEFT,
    output logic IND_RIGHT
);
    ivpc_pkg::ivpc_state_type state;
    logic [31:0] timer;
    logic [7:0] half;
    logic [7:0] phase_cnt;
    logic phase;
    logic [15:0] target;
    logic [15:0] meas;
    logic retry_en;
    logic start_pulse;
    logic stop_pulse;
    logic wr_ok;
    logic setup;
    logic ping_timeout;

    ivpc_pid_if pif ();

    ivpc_pid u_pid (
        .clk(CLK),
        .rst(RST),
        .bus(pif)
    );

    assign pif.strobe = SAMPLE_VALID && (state == ivpc_pkg::ST_XFER); // RL7
    assign pif.target = target;
    assign pif.meas = COIL_MV; // RL8
    assign pif.vset_in = VSET;

    // APB: setup edge latches the answer, so the access phase lasts one cycle
    assign setup = PSEL && !PENABLE;
    assign wr_ok = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
    assign start_pulse = wr_ok && (PADDR == ivpc_pkg::OFF_CTRL) && PWDATA[ivpc_pkg::CTRL_START];
    assign stop_pulse = wr_ok && (PADDR == ivpc_pkg::OFF_CTRL) && PWDATA[ivpc_pkg::CTRL_STOP];
    assign ping_timeout = (state == ivpc_pkg::ST_PING) && !SS_RX && (timer == 32'h0000_0000);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
        end else begin
            PREADY <= setup;
            if (setup) begin
                PSLVERR <= 1'b0;
                PRDATA <= 32'h0000_0000;
                if (PADDR == ivpc_pkg::OFF_CTRL) begin
                    PRDATA <= {29'h0000_0000, retry_en, 2'b00};
                end else if (PADDR == ivpc_pkg::OFF_TARGET) begin
                    PRDATA <= {16'h0000, target};
                end else if (PADDR == ivpc_pkg::OFF_STATUS) begin
                    PRDATA <= {21'h00_0000, IND_RIGHT, IND_LEFT, PWR_EN, 4'h0, state};
                end else if (PADDR == ivpc_pkg::OFF_VSET) begin
                    PRDATA <= {16'h0000, VSET};
                end else if (PADDR == ivpc_pkg::OFF_HALF) begin
                    PRDATA <= {24'h00_0000, half};
                end else if (PADDR == ivpc_pkg::OFF_MEAS) begin
                    PRDATA <= {16'h0000, meas};
                end else begin
                    PSLVERR <= 1'b1;
                end
            end else begin
                PSLVERR <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            target <= ivpc_pkg::TARGET_RESET;
            retry_en <= 1'b0;
        end else if (wr_ok) begin
            if (PADDR == ivpc_pkg::OFF_TARGET) begin
                target <= PWDATA[15:0];
            end else if (PADDR == ivpc_pkg::OFF_CTRL) begin
                retry_en <= PWDATA[ivpc_pkg::CTRL_RETRY];
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            meas <= 16'h0000;
        end else if (SAMPLE_VALID) begin
            meas <= COIL_MV; // RL8
        end
    end

    // Ping sequencer
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state <= ivpc_pkg::ST_OFF;
            timer <= 32'h0000_0000;
            half <= ivpc_pkg::HALF_PING;
        end else if (stop_pulse) begin
            state <= ivpc_pkg::ST_OFF;
            timer <= 32'h0000_0000;
        end else begin
            case (state)
                ivpc_pkg::ST_OFF: begin
                    if (start_pulse) begin
                        state <= ivpc_pkg::ST_PING;
                        half <= ivpc_pkg::HALF_PING; // RL4
                        timer <= 32'(PING_CYC - 1);
                    end
                end
                ivpc_pkg::ST_PING: begin
                    if (SS_RX) begin
                        state <= ivpc_pkg::ST_XFER; // RL6
                    end else if (timer == 32'h0000_0000) begin
                        if (retry_en && (half < ivpc_pkg::HALF_LOW)) begin
                            state <= ivpc_pkg::ST_GAP;
                            half <= half + 8'h01; // RL6
                            timer <= 32'(GAP_CYC - 1);
                        end else begin
                            state <= ivpc_pkg::ST_OFF; // RL5
                        end
                    end else begin
                        timer <= timer - 32'h0000_0001;
                    end
                end
                ivpc_pkg::ST_GAP: begin
                    if (timer == 32'h0000_0000) begin
                        state <= ivpc_pkg::ST_PING;
                        timer <= 32'(PING_CYC - 1);
                    end else begin
                        timer <= timer - 32'h0000_0001;
                    end
                end
                ivpc_pkg::ST_XFER: begin
                    state <= ivpc_pkg::ST_XFER;
                end
                default: begin
                    state <= ivpc_pkg::ST_OFF;
                end
            endcase
        end
    end

    // Power signal enable follows the next state so it is a plain flop
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PWR_EN <= 1'b0;
        end else if (stop_pulse || ping_timeout) begin
            PWR_EN <= 1'b0; // RL5
        end else if ((state == ivpc_pkg::ST_OFF && start_pulse) ||
                     (state == ivpc_pkg::ST_GAP && timer == 32'h0000_0000)) begin
            PWR_EN <= 1'b1;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            VSET <= ivpc_pkg::VSET_MIN;
        end else if ((state == ivpc_pkg::ST_OFF && start_pulse) ||
                     (state == ivpc_pkg::ST_GAP && timer == 32'h0000_0000)) begin
            VSET <= ivpc_pkg::VSET_PING; // RL3
        end else if (pif.done && state == ivpc_pkg::ST_XFER) begin
            VSET <= pif.vset_out; // RL7 RL1
        end
    end

    // Full-bridge drive: complementary square wave at the current half period
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            phase_cnt <= 8'h00;
            phase <= 1'b0;
        end else if (!PWR_EN) begin
            phase_cnt <= 8'h00;
            phase <= 1'b0;
        end else if (phase_cnt >= half - 8'h01) begin
            phase_cnt <= 8'h00;
            phase <= !phase;
        end else begin
            phase_cnt <= phase_cnt + 8'h01;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            BRIDGE_A <= 1'b0;
            BRIDGE_B <= 1'b0;
        end else begin
            BRIDGE_A <= PWR_EN && phase;
            BRIDGE_B <= PWR_EN && !phase;
        end
    end

    // Alignment guidance: both lamps lit means centred
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            IND_LEFT <= 1'b0;
            IND_RIGHT <= 1'b0;
        end else if (DET_VALID) begin
            IND_LEFT <= DET_OFFSET <= ivpc_pkg::DIR_TOL; // RL10
            IND_RIGHT <= DET_OFFSET >= -ivpc_pkg::DIR_TOL;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_ping_start;
        state == ivpc_pkg::ST_OFF && start_pulse && !stop_pulse;
    endsequence

    sequence s_ping_retry;
        ping_timeout && !stop_pulse && retry_en && half < ivpc_pkg::HALF_LOW;
    endsequence

    a_vset_range: assert property (VSET >= ivpc_pkg::VSET_MIN && VSET <= ivpc_pkg::VSET_MAX) // RL1
        else $error("setpoint outside 3 to 12 V");
    a_ping_volt: assert property ($rose(PWR_EN) |-> VSET == ivpc_pkg::VSET_PING) // RL3
        else $error("ping not at 5.7 V");
    a_ping_freq: assert property (s_ping_start |=> half == ivpc_pkg::HALF_PING && PWR_EN) // RL4
        else $error("first ping not at top frequency");
    a_no_ss_off: assert property (ping_timeout && !stop_pulse |=> !PWR_EN ##1 !PWR_EN) // RL5
        else $error("power signal kept after silent ping");
    a_retry_lower: assert property (s_ping_retry |=> // RL6
        half == $past(half) + 8'h01 && state == ivpc_pkg::ST_GAP) else $error("retry not at lower frequency");
    a_retry_band: assert property (half >= ivpc_pkg::HALF_PING && half <= ivpc_pkg::HALF_LOW) // RL6
        else $error("drive frequency outside band");
    a_ss_stops: assert property (state == ivpc_pkg::ST_PING && SS_RX && !stop_pulse |=> // RL6
        state == ivpc_pkg::ST_XFER) else $error("signal strength did not end ping");
    a_loop_update: assert property (pif.strobe && !stop_pulse ##1 pif.done && state == ivpc_pkg::ST_XFER // RL7
        |=> VSET == $past(pif.vset_out)) else $error("loop did not move setpoint");
    a_ind_dir: assert property (DET_VALID && DET_OFFSET > ivpc_pkg::DIR_TOL |=> IND_RIGHT && !IND_LEFT) // RL10
        else $error("direction indication wrong");
endmodule

// >>> verilog/ivpc_pkg.sv
// Overview of operation
// RL1: Power is set by the inverter supply setpoint, kept within 3 to 12 V.
// RL2: Setpoint moves in 0.5 mV steps, far finer than 50 mV.
// RL3: Each ping starts with a 5.7 V supply setpoint.
// RL4: The first ping drives the bridge at about 140 kHz.
// RL5: Without a signal strength packet the ping window ends with power off.
// RL6: Optional retries at successively lower frequency, down to 105 kHz, until received.
// RL7: During transfer a PID loop adjusts the supply setpoint.
// RL8: Coil voltage feedback is taken in 1 mV units, finer than 5 mV.
// RL9: Gains 1/0/0, no integral limit, output limit 1500, scale -0.5 mV.
// RL10: Two direction indicators guide the user toward the charging area.
// RL11: Clip loop output, scale to a step, clamp setpoint to the range.
package ivpc_pkg;
    localparam int CLK_HZ = 10_000_000;
    // Setpoint unit is 0.5 mV
    localparam int V_MIN_MV = 3000;
    localparam int V_MAX_MV = 12000;
    localparam int V_PING_MV = 5700;
    localparam logic [15:0] VSET_MIN = 16'(V_MIN_MV * 2);
    localparam logic [15:0] VSET_MAX = 16'(V_MAX_MV * 2);
    localparam logic [15:0] VSET_PING = 16'(V_PING_MV * 2);
    localparam int PID_KP = 1;
    localparam logic signed [17:0] PID_LIMIT = 18'sd1500;
    // Scale of -0.5 mV per count is minus one setpoint unit
    localparam int PID_SCALE_UNITS = -1;
    localparam int F_PING_HZ = 140_000;
    localparam int F_LOW_HZ = 105_000;
    // Half periods in clocks: round up at the top, down at the bottom to stay in band
    localparam logic [7:0] HALF_PING = 8'((CLK_HZ + 2 * F_PING_HZ - 1) / (2 * F_PING_HZ));
    localparam logic [7:0] HALF_LOW = 8'(CLK_HZ / (2 * F_LOW_HZ));
    localparam int PING_TIME_US = 65000;
    localparam int GAP_TIME_US = 10000;
    localparam logic signed [7:0] DIR_TOL = 8'sh04;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_TARGET = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_VSET = 8'h0C;
    localparam logic [7:0] OFF_HALF = 8'h10;
    localparam logic [7:0] OFF_MEAS = 8'h14;
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_RETRY = 2;
    localparam logic [15:0] TARGET_RESET = 16'h0000;
    typedef enum logic [3:0] {
        ST_OFF = 4'b0001,
        ST_PING = 4'b0010,
        ST_GAP = 4'b0100,
        ST_XFER = 4'b1000
    } ivpc_state_type;
endpackage

// >>> verilog/ivpc_pid_if.sv
`timescale 1ns/1ns
interface ivpc_pid_if;
    logic strobe;
    logic [15:0] target;
    logic [15:0] meas;
    logic [15:0] vset_in;
    logic [15:0] vset_out;
    logic done;
    modport ctl (output strobe, output target, output meas, output vset_in, input vset_out, input done);
    modport pid (input strobe, input target, input meas, input vset_in, output vset_out, output done);
endinterface

// >>> verilog/ivpc_pid.sv
`timescale 1ns/1ns
module ivpc_pid (
    input wire logic clk,
    input wire logic rst,
    ivpc_pid_if.pid bus
);
    logic signed [17:0] err;
    logic signed [17:0] clip;
    logic signed [18:0] sum;
    logic [15:0] next_vset;

    always_comb begin
        // Proportional only: integral and derivative gains are zero
        err = 18'(ivpc_pkg::PID_KP) * (18'($signed({2'b00, bus.target})) - 18'($signed({2'b00, bus.meas}))); // RL9 RL8
        if (err > ivpc_pkg::PID_LIMIT) begin
            clip = ivpc_pkg::PID_LIMIT; // RL11
        end else if (err < -ivpc_pkg::PID_LIMIT) begin
            clip = -ivpc_pkg::PID_LIMIT;
        end else begin
            clip = err;
        end
        sum = 19'($signed({3'b000, bus.vset_in})) + 19'(ivpc_pkg::PID_SCALE_UNITS) * 19'(clip); // RL11 RL2
        if (sum < 19'($signed({3'b000, ivpc_pkg::VSET_MIN}))) begin
            next_vset = ivpc_pkg::VSET_MIN; // RL1
        end else if (sum > 19'($signed({3'b000, ivpc_pkg::VSET_MAX}))) begin
            next_vset = ivpc_pkg::VSET_MAX;
        end else begin
            next_vset = sum[15:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus.vset_out <= 16'h0000;
            bus.done <= 1'b0;
        end else begin
            bus.done <= bus.strobe;
            if (bus.strobe) begin
                bus.vset_out <= next_vset;
            end
        end
    end

    a_clip_bound: assert property (@(posedge clk) disable iff (rst) // RL9
        bus.strobe |-> (clip <= ivpc_pkg::PID_LIMIT) && (clip >= -ivpc_pkg::PID_LIMIT))
        else $error("loop output not clipped");
    // Away from both range ends the new setpoint is the old one minus the clipped error
    a_step_scale: assert property (@(posedge clk) disable iff (rst) // RL11
        bus.strobe && (bus.vset_in >= ivpc_pkg::VSET_MIN + 16'(ivpc_pkg::PID_LIMIT))
        && (bus.vset_in <= ivpc_pkg::VSET_MAX - 16'(ivpc_pkg::PID_LIMIT))
        |=> bus.vset_out == 16'($past(bus.vset_in) - 16'($past(clip))))
        else $error("step not scaled by minus half mV");
    a_clamp_range: assert property (@(posedge clk) disable iff (rst) // RL11
        bus.done |-> bus.vset_out >= ivpc_pkg::VSET_MIN && bus.vset_out <= ivpc_pkg::VSET_MAX)
        else $error("setpoint left supply range");
endmodule

// >>> tb/ivpc_rx_model.sv
`timescale 1ns/1ns
module ivpc_rx_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic pwr_en,
    input wire logic answer_en,
    input wire logic [7:0] dly,
    output logic ss_rx
);
    logic [7:0] cnt;
    logic sent;
    // One signal strength report per powered ping, after the receiver's wake-up delay
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 8'h00;
            sent <= 1'h0;
            ss_rx <= 1'h0;
        end else begin
            ss_rx <= 1'h0;
            if (!pwr_en) begin
                cnt <= 8'h00;
                sent <= 1'h0;
            end else if (answer_en && !sent) begin
                if (cnt >= dly) begin
                    ss_rx <= 1'h1;
                    sent <= 1'h1;
                end else begin
                    cnt <= cnt + 8'h01;
                end
            end
        end
    end
endmodule

// >>> tb/ivpc_tb_top.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module ivpc_tb_top;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, ss_rx, pwr_en, bridge_a, bridge_b, ind_left, ind_right;
    logic sample_valid = 1'h0;
    logic det_valid = 1'h0;
    logic answer_en = 1'h0;
    logic [15:0] coil_mv = 16'h0000;
    logic [15:0] vset;
    logic signed [7:0] det_offset = 8'sh00;
    logic [7:0] dly = 8'h00;
    logic [40:0] exp_q[$];
    logic [40:0] e_top;
    int errors = 0;
    int checks_done = 0;
    int hi_len = 0;
    int seed = 32'h17232BF0;
    int vs;
    int n;
    int offs[6] = '{5, -4, 127, -5, -128, 0};
    localparam int TGT = 8000;
    always #50 clk = ~clk;

    ivpc_top #(.PING_CYC(20), .GAP_CYC(5)) i_dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SS_RX(ss_rx), .SAMPLE_VALID(sample_valid), .COIL_MV(coil_mv),
        .DET_VALID(det_valid), .DET_OFFSET(det_offset), .VSET(vset), .PWR_EN(pwr_en),
        .BRIDGE_A(bridge_a), .BRIDGE_B(bridge_b), .IND_LEFT(ind_left), .IND_RIGHT(ind_right));
    ivpc_rx_model i_rx (.clk(clk), .rst(rst), .pwr_en(pwr_en), .answer_en(answer_en), .dly(dly),
        .ss_rx(ss_rx));

    // Each completed read takes the oldest expectation: {address, error flag, data}
    always @(posedge clk) begin
        if (psel && penable && pready === 1'h1 && !pwrite) begin
            e_top = exp_q.size() > 0 ? exp_q.pop_front() : {paddr, 33'h1FFFFFFFF};
            `CHK($sformatf("reg 0x%h", e_top[40:33]), e_top[32:0], {pslverr, prdata})
        end
    end

    // While powered, bridge A stays high for one half period of the top ping frequency
    always @(posedge clk) begin
        if (bridge_a === 1'h1) begin
            hi_len++;
        end else if (hi_len > 0) begin
            if (pwr_en === 1'h1 && bridge_b === 1'h1) begin
                `CHK("bridge half period", int'(ivpc_pkg::HALF_PING), hi_len)
            end
            hi_len = 0;
        end
    end

    task automatic results;
        if (errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back({a, e});
        apb(1'h0, a, 32'h0);
    endtask

    function automatic logic [32:0] stat(input int s, input int p, input int l, input int r);
        return 33'(s + 256 * p + 512 * l + 1024 * r);
    endfunction

    task automatic wait_pwr(input logic v);
        n = 0;
        while (pwr_en !== v && n < 100) begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic sample(input logic [15:0] c);
        int e;
        sample_valid <= 1'h1;
        coil_mv <= c;
        e = TGT - int'(c);
        e = e > 1500 ? 1500 : (e < -1500 ? -1500 : e);
        vs = vs - e;
        vs = vs < int'(ivpc_pkg::VSET_MIN) ? int'(ivpc_pkg::VSET_MIN) : vs;
        vs = vs > int'(ivpc_pkg::VSET_MAX) ? int'(ivpc_pkg::VSET_MAX) : vs;
        @(posedge clk);
        sample_valid <= 1'h0;
        repeat (2) @(posedge clk);
        rd(ivpc_pkg::OFF_VSET, 33'(vs));
    endtask

    task automatic det(input int off);
        det_valid <= 1'h1;
        det_offset <= 8'(off);
        @(posedge clk);
        det_valid <= 1'h0;
        @(posedge clk);
        rd(ivpc_pkg::OFF_STATUS, stat(8, 1, int'(off <= 4), int'(off >= -4)));
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        results();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        rd(ivpc_pkg::OFF_STATUS, stat(1, 0, 0, 0));
        rd(ivpc_pkg::OFF_VSET, 33'(ivpc_pkg::VSET_MIN));
        rd(ivpc_pkg::OFF_CTRL, 33'h0);
        rd(8'h18, 33'h100000000);
        apb(1'h1, ivpc_pkg::OFF_TARGET, TGT);
        rd(ivpc_pkg::OFF_TARGET, 33'(TGT));
        apb(1'h1, ivpc_pkg::OFF_CTRL, 32'h1);
        rd(ivpc_pkg::OFF_STATUS, stat(2, 1, 0, 0));
        rd(ivpc_pkg::OFF_VSET, 33'(ivpc_pkg::VSET_PING));
        rd(ivpc_pkg::OFF_HALF, 33'(ivpc_pkg::HALF_PING));
        wait_pwr(1'h0);
        rd(ivpc_pkg::OFF_STATUS, stat(1, 0, 0, 0));
        // Silent receiver: retries walk down to the lowest frequency, then give up
        apb(1'h1, ivpc_pkg::OFF_CTRL, 32'h5);
        for (int k = 1; k <= int'(ivpc_pkg::HALF_LOW - ivpc_pkg::HALF_PING); k++) begin
            wait_pwr(1'h0);
            rd(ivpc_pkg::OFF_STATUS, stat(4, 0, 0, 0));
            wait_pwr(1'h1);
            rd(ivpc_pkg::OFF_HALF, 33'(int'(ivpc_pkg::HALF_PING) + k));
            rd(ivpc_pkg::OFF_VSET, 33'(ivpc_pkg::VSET_PING));
        end
        wait_pwr(1'h0);
        rd(ivpc_pkg::OFF_STATUS, stat(1, 0, 0, 0));
        dly <= 8'($random(seed) & 7);
        answer_en <= 1'h1;
        apb(1'h1, ivpc_pkg::OFF_CTRL, 32'h5);
        n = 0;
        while (ss_rx !== 1'h1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        rd(ivpc_pkg::OFF_STATUS, stat(8, 1, 0, 0));
        vs = int'(ivpc_pkg::VSET_PING);
        for (int i = 0; i < 17; i++) sample(i < 4 ? 16'h0000 : 16'hF000);
        for (int i = 0; i < 8; i++) sample(16'($random(seed)));
        for (int i = 0; i < 4; i++) sample(16'(TGT + $random(seed) % 4));
        rd(ivpc_pkg::OFF_MEAS, 33'(coil_mv));
        foreach (offs[i]) det(offs[i]);
        apb(1'h1, ivpc_pkg::OFF_CTRL, 32'h2);
        rd(ivpc_pkg::OFF_STATUS, stat(1, 0, 1, 1));
        repeat (2) @(posedge clk);
        `CHK("pending reads", 0, exp_q.size())
        results();
    end
endmodule
